// >>> design/nvp_host.sv
// Host controller driving the nonvolatile byte memory over its parallel pins
module nvp_host (
    input  wire logic                          ref_clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          req_i,
    input  wire logic                          we_i,
    input  wire logic [nvp_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [nvp_pkg::DATA_W-1:0]    wdata_i,
    output logic                               ready_o,
    output logic                               rvalid_o,
    output logic                               done_o,
    output logic [nvp_pkg::DATA_W-1:0]         rdata_o,
    input  wire logic [nvp_pkg::DATA_W-1:0]    data_bus_i,
    output nvp_pkg::nvp_pins_s                 pins_o
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (nvp_pkg::PRE_CYC < 2 || nvp_pkg::ACCESS_CYC + nvp_pkg::SYNC_CYC >= 255)
    begin : g_chk
        $error("nvp_host: timing counts out of range");
    end

    // ----------------------------------------
    // State and request latch
    // ----------------------------------------
    nvp_pkg::nvp_state_e           state;
    nvp_pkg::nvp_state_e           next_state;
    logic [nvp_pkg::CNT_W-1:0]     cnt;
    logic [nvp_pkg::CNT_W-1:0]     next_cnt;
    logic                          pend;
    logic                          op_we;
    logic [nvp_pkg::ADDR_W-1:0]    op_addr;
    logic [nvp_pkg::DATA_W-1:0]    op_wdata;
    logic                          take;
    logic                          same_row;
    logic [nvp_pkg::DATA_W-1:0]    dq_s1;
    logic [nvp_pkg::DATA_W-1:0]    dq_s2;
    logic [nvp_pkg::DATA_W-1:0]    dq_s3;
    logic [nvp_pkg::DATA_W-1:0]    dq_stable;

    assign take     = req_i && ready_o;
    assign same_row = nvp_pkg::row_of(addr_i) == nvp_pkg::row_of(pins_o.addr);

    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
        case (state)
            nvp_pkg::S_IDLE:
                if (take)
                    next_state = nvp_pkg::S_ARM;
            nvp_pkg::S_ARM:
            begin
                next_state = nvp_pkg::S_ACC;
                next_cnt   = op_we ? nvp_pkg::CNT_W'(nvp_pkg::ACCESS_CYC - 1)
                                   : nvp_pkg::CNT_W'(nvp_pkg::ACCESS_CYC
                                                     + nvp_pkg::SYNC_CYC - 1);
            end
            nvp_pkg::S_ACC:
                if (cnt == '0)
                    next_state = op_we ? nvp_pkg::S_CEND : nvp_pkg::S_OPEN;
            nvp_pkg::S_CEND:
            begin
                next_state = nvp_pkg::S_PRE;
                next_cnt   = nvp_pkg::CNT_W'(nvp_pkg::PRE_CYC - 2);
            end
            nvp_pkg::S_OPEN:
                if (take && same_row && we_i)
                    next_state = nvp_pkg::S_PARM;
                else if (take && same_row)
                begin
                    next_state = nvp_pkg::S_ACC;
                    next_cnt   = nvp_pkg::CNT_W'(nvp_pkg::PAGE_CYC + nvp_pkg::SYNC_CYC - 1);
                end
                else if (take)
                begin
                    next_state = nvp_pkg::S_PRE;
                    next_cnt   = nvp_pkg::CNT_W'(nvp_pkg::PRE_CYC - 1);
                end
            nvp_pkg::S_PARM:
            begin
                next_state = nvp_pkg::S_PWR;
                next_cnt   = nvp_pkg::CNT_W'(nvp_pkg::ACCESS_CYC - 1);
            end
            nvp_pkg::S_PWR:
                if (cnt == '0)
                    next_state = nvp_pkg::S_PEND;
            nvp_pkg::S_PEND:
                next_state = nvp_pkg::S_OPEN;
            nvp_pkg::S_PRE:
                if (cnt == '0)
                    next_state = pend ? nvp_pkg::S_ARM : nvp_pkg::S_IDLE;
            default:
                next_state = nvp_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            state <= nvp_pkg::S_IDLE;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            op_we    <= 1'b0;
            op_addr  <= nvp_pkg::ADDR_RST;
            op_wdata <= nvp_pkg::DATA_RST;
            pend     <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                op_we    <= we_i;
                op_addr  <= addr_i;
                op_wdata <= wdata_i;
            end
            if (state == nvp_pkg::S_OPEN && take && !same_row)
                pend <= 1'b1;
            else if (state == nvp_pkg::S_ARM)
                pend <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            pins_o.primary_select_n <= 1'b1;
            pins_o.secondary_select <= 1'b1;
            pins_o.we_n             <= 1'b1;
            pins_o.oe_n             <= 1'b1;
            pins_o.addr             <= nvp_pkg::ADDR_RST;
            pins_o.data_bus         <= nvp_pkg::DATA_RST;
            pins_o.data_bus_oe      <= 1'b0;
        end
        else
        begin
            pins_o.secondary_select <= 1'b1;
            case (state)
                nvp_pkg::S_IDLE:
                    if (take)
                    begin
                        pins_o.addr        <= addr_i;
                        pins_o.we_n        <= !we_i;
                        pins_o.oe_n        <= we_i;
                        pins_o.data_bus    <= wdata_i;
                        pins_o.data_bus_oe <= we_i;
                    end
                nvp_pkg::S_PRE:
                    if (cnt == '0 && pend)
                    begin
                        pins_o.addr        <= op_addr;
                        pins_o.we_n        <= !op_we;
                        pins_o.oe_n        <= op_we;
                        pins_o.data_bus    <= op_wdata;
                        pins_o.data_bus_oe <= op_we;
                    end
                nvp_pkg::S_ARM:
                    pins_o.primary_select_n <= 1'b0;
                nvp_pkg::S_ACC:
                    if (cnt == '0 && op_we)
                        pins_o.primary_select_n <= 1'b1;
                nvp_pkg::S_CEND:
                begin
                    pins_o.we_n        <= 1'b1;
                    pins_o.data_bus_oe <= 1'b0;
                end
                nvp_pkg::S_OPEN:
                    if (take && same_row)
                    begin
                        pins_o.addr     <= addr_i;
                        // Output drive off a cycle before we drive, no contention
                        pins_o.oe_n     <= we_i;
                        pins_o.data_bus <= wdata_i;
                    end
                    else if (take)
                    begin
                        pins_o.primary_select_n <= 1'b1;
                        pins_o.oe_n             <= 1'b1;
                    end
                nvp_pkg::S_PARM:
                begin
                    pins_o.data_bus_oe <= 1'b1;
                    pins_o.we_n        <= 1'b0;
                end
                nvp_pkg::S_PWR:
                    if (cnt == '0)
                        pins_o.we_n <= 1'b1;
                nvp_pkg::S_PEND:
                    pins_o.data_bus_oe <= 1'b0;
                default:
                    pins_o.primary_select_n <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Read capture and user handshake
    // ----------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            dq_s1     <= nvp_pkg::DATA_RST;
            dq_s2     <= nvp_pkg::DATA_RST;
            dq_s3     <= nvp_pkg::DATA_RST;
            dq_stable <= nvp_pkg::DATA_RST;
        end
        else
        begin
            dq_s1 <= data_bus_i;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
            if (dq_s2 == dq_s3)
                dq_stable <= dq_s3;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            ready_o  <= 1'b0;
            rvalid_o <= 1'b0;
            done_o   <= 1'b0;
            rdata_o  <= nvp_pkg::DATA_RST;
        end
        else
        begin
            // Row may stay open indefinitely between requests
            ready_o  <= next_state == nvp_pkg::S_IDLE || next_state == nvp_pkg::S_OPEN;
            rvalid_o <= state == nvp_pkg::S_ACC && cnt == '0 && !op_we;
            // No busy polling: a write is done once its bus cycle ends
            done_o   <= state == nvp_pkg::S_CEND || state == nvp_pkg::S_PEND;
            // Agreeing stages count at once; the registered copy lags a cycle
            if (state == nvp_pkg::S_ACC && cnt == '0 && !op_we)
                rdata_o <= (dq_s2 == dq_s3) ? dq_s3 : dq_stable;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [nvp_pkg::CNT_W-1:0] desel_cnt;
    logic [nvp_pkg::CNT_W-1:0] we_low_cnt;
    logic [nvp_pkg::CNT_W-1:0] fall_gap;
    localparam int PC_MIN  = nvp_pkg::PC_CYC;
    localparam int RC_MIN  = nvp_pkg::CYCLE_CYC;
    localparam int ACC_MIN = nvp_pkg::ACCESS_CYC;

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            desel_cnt  <= '1;
            we_low_cnt <= '0;
            fall_gap   <= '1;
        end
        else
        begin
            desel_cnt  <= !pins_o.primary_select_n ? '0
                        : (desel_cnt != '1) ? desel_cnt + 1'b1 : desel_cnt;
            we_low_cnt <= pins_o.we_n ? '0
                        : (we_low_cnt != '1) ? we_low_cnt + 1'b1 : we_low_cnt;
            fall_gap   <= (next_state == nvp_pkg::S_ACC && state == nvp_pkg::S_ARM) ? '0
                        : (fall_gap != '1) ? fall_gap + 1'b1 : fall_gap;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    ce_write_data_a: assert property (
        $rose(pins_o.primary_select_n) && !pins_o.we_n |-> pins_o.data_bus_oe)
        else $error("write data not driven at deselect");
    precharge_min_a: assert property (
        $fell(pins_o.primary_select_n) |-> $past(desel_cnt) >= PC_MIN - 1)
        else $error("select reactivated before precharge time");
    access_met_a: assert property (
        $rose(pins_o.we_n) |-> $past(we_low_cnt) >= ACC_MIN - 1)
        else $error("write strobe ended before access time");
    data_stable_a: assert property (
        !pins_o.we_n && $past(!pins_o.we_n) |-> $stable(pins_o.data_bus))
        else $error("write data changed while strobe low");
    one_strobe_a: assert property (
        $fell(pins_o.we_n) |=> !pins_o.we_n [*5] ##[1:20] pins_o.we_n)
        else $error("strobe pulse shape wrong");
    reset_we_a: assert property (
        disable iff (1'b0) !nrst_i |=> pins_o.we_n && pins_o.primary_select_n)
        else $error("strobe or select active after reset");
    row_change_a: assert property (
        $changed(pins_o.addr[nvp_pkg::ADDR_W-1:nvp_pkg::COL_W]) |-> pins_o.primary_select_n)
        else $error("row changed while selected");
    page_row_a: assert property (
        $fell(pins_o.we_n) && $past(!pins_o.primary_select_n)
        |-> $stable(pins_o.addr[nvp_pkg::ADDR_W-1:nvp_pkg::COL_W]))
        else $error("page write left the open row");
    spacing_a: assert property (
        state == nvp_pkg::S_ARM && fall_gap != '1 |-> fall_gap >= RC_MIN - 2)
        else $error("random accesses too close");
    no_fight_a: assert property (
        pins_o.data_bus_oe |-> pins_o.oe_n)
        else $error("bus driven with memory output enabled");
    read_lat_a: assert property (
        state == nvp_pkg::S_ARM && !op_we |-> ##[9:11] rvalid_o)
        else $error("read answer late");

    ce_read_c:    cover property (state == nvp_pkg::S_ARM && !op_we ##[1:20] rvalid_o);
    ce_write_c:   cover property ($rose(pins_o.primary_select_n) && !pins_o.we_n);
    page_read_c:  cover property (state == nvp_pkg::S_OPEN && take && same_row && !we_i);
    page_write_c: cover property ($fell(pins_o.we_n) && $past(!pins_o.primary_select_n));

endmodule

// >>> design/nvp_pkg.sv
// Constants, pin bundle and state codes for the byte memory port controller
package nvp_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int ACCESS_NS     = 60;
    localparam int CYCLE_NS      = 90;
    localparam int PAGE_NS       = 30;
    localparam int PRECHARGE_NS  = 30;

    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACCESS_CYC = ns_to_cycles(ACCESS_NS);
    localparam int CYCLE_CYC  = ns_to_cycles(CYCLE_NS);
    localparam int PAGE_CYC   = ns_to_cycles(PAGE_NS);
    localparam int PC_CYC     = ns_to_cycles(PRECHARGE_NS);
    localparam int PRE_CYC    = (PC_CYC > CYCLE_CYC - ACCESS_CYC) ? PC_CYC
                                                                  : CYCLE_CYC - ACCESS_CYC;
    // Three synchroniser stages plus the agreement register
    localparam int SYNC_CYC   = 4;
    localparam int CNT_W      = 8;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int COL_W  = 3;

    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef struct packed {
        logic              primary_select_n;
        logic              secondary_select;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_bus;
        logic              data_bus_oe;
    } nvp_pins_s;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ARM  = 9'h002,
        S_ACC  = 9'h004,
        S_CEND = 9'h008,
        S_OPEN = 9'h010,
        S_PARM = 9'h020,
        S_PWR  = 9'h040,
        S_PEND = 9'h080,
        S_PRE  = 9'h100
    } nvp_state_e;

    function automatic logic [ADDR_W-COL_W-1:0] row_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:COL_W];
    endfunction

endpackage

// >>> testbench/nvp_mem_model.sv
// Behavioural model of the byte memory behind the host pins
module nvp_mem_model #(
    parameter int ACC_NS = 60,
    parameter int PG_NS  = 30,
    parameter int CYC_NS = 90,
    parameter int PC_NS  = 30
) (
    input  wire nvp_pkg::nvp_pins_s pins_i,
    input  wire logic [7:0]         dq_i,
    output logic [7:0]              dq_o,
    output logic                    dq_oe_o,
    output int                      viol_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Array and access state
    // ----------------------------------------
    logic [7:0]  mem [0:131071];
    logic [16:0] lat, wa;
    logic        wr_open = 1'b0;
    logic        sel;
    realtime     rdy_at = 0, act_at = -1000, off_at = -1000, wr_at = 0;

    // Secondary select reads high when undriven
    assign sel = !pins_i.primary_select_n && pins_i.secondary_select !== 1'b0;

    initial
    begin
        viol_o  = 0;
        dq_oe_o = 1'b0;
        lat     = 17'h00000;
        for (int i = 0; i < 131072; i++) mem[i] = 8'(i) ^ 8'(i >> 9);
        #0.3;
        forever
        begin
            // Off-edge polling keeps bus changes clear of clock races
            dq_oe_o = sel && !pins_i.oe_n && pins_i.we_n && $realtime >= rdy_at;
            dq_o    = mem[lat];
            if (dq_oe_o && pins_i.data_bus_oe) viol_o++;
            #1;
        end
    end

    // ----------------------------------------
    // Activation, row and column changes
    // ----------------------------------------
    always @(posedge sel)
    begin
        if ($realtime - off_at < PC_NS) viol_o++;
        if ($realtime - act_at < CYC_NS) viol_o++;
        act_at  = $realtime;
        lat     = pins_i.addr;
        rdy_at  = $realtime + ACC_NS;
        wr_open = !pins_i.we_n;
        wa      = pins_i.addr;
        wr_at   = $realtime;
    end

    always @(negedge sel) off_at = $realtime;

    always @(pins_i.addr)
    begin
        if (sel && pins_i.we_n)
        begin
            if (pins_i.addr[16:3] != lat[16:3]) rdy_at = $realtime + ACC_NS;
            else if ($realtime + PG_NS > rdy_at) rdy_at = $realtime + PG_NS;
            lat = pins_i.addr;
        end
    end

    // ----------------------------------------
    // Writes
    // ----------------------------------------
    always @(negedge pins_i.we_n)
    begin
        if (sel)
        begin
            wr_open = 1'b1;
            wa      = pins_i.addr;
            wr_at   = $realtime;
        end
    end

    always @(posedge pins_i.we_n or negedge sel)
    begin
        if (wr_open)
        begin
            if ($realtime - wr_at < ACC_NS) viol_o++;
            mem[wa] = dq_i;
            wr_open = 1'b0;
        end
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the byte memory host controller
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    typedef struct packed {
        logic       is_read;
        logic [7:0] data;
    } nvp_note_s;

    logic                        ref_clk_i = 1'b0;
    logic                        nrst_i    = 1'b0;
    logic                        req_i     = 1'b0;
    logic                        we_i      = 1'b0;
    logic [nvp_pkg::ADDR_W-1:0]  addr_i    = 17'h00000;
    logic [nvp_pkg::DATA_W-1:0]  wdata_i   = 8'h00;
    logic                        ready_o, rvalid_o, done_o, mem_oe;
    logic [7:0]                  rdata_o, dq_wire, mem_dq;
    logic [7:0]                  bus_last  = 8'h00;
    int                          viol;
    int                          err_count = 0;
    int                          compares  = 0;
    nvp_pkg::nvp_pins_s          pins;
    nvp_note_s                   note;
    nvp_note_s                   notes[$];
    logic [7:0]                  shadow[int];

    always #5 ref_clk_i = ~ref_clk_i;

    // Released bus shows a changing pattern, not a stale byte
    assign dq_wire = pins.data_bus_oe ? pins.data_bus : (mem_oe ? mem_dq : ~bus_last);
    always @(posedge ref_clk_i) bus_last <= dq_wire;

    nvp_host nvp_host_i (
        .ref_clk_i  (ref_clk_i),
        .nrst_i     (nrst_i),
        .req_i      (req_i),
        .we_i       (we_i),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .ready_o    (ready_o),
        .rvalid_o   (rvalid_o),
        .done_o     (done_o),
        .rdata_o    (rdata_o),
        .data_bus_i (dq_wire),
        .pins_o     (pins)
    );

    nvp_mem_model nvp_mem_model_i (
        .pins_i  (pins),
        .dq_i    (dq_wire),
        .dq_o    (mem_dq),
        .dq_oe_o (mem_oe),
        .viol_o  (viol)
    );

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check1(input string name, input logic exp, input logic got);
        check8(name, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic stop_test();
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [7:0] expect_byte(input logic [16:0] a);
        if (shadow.exists(int'(a))) return shadow[int'(a)];
        return a[7:0] ^ a[16:9];
    endfunction

    always @(negedge ref_clk_i)
    begin
        if (rvalid_o === 1'b1 || done_o === 1'b1)
        begin
            if (notes.size() == 0)
                check1("spare result", 1'b0, 1'b1);
            else
            begin
                note = notes.pop_front();
                check1("result kind", note.is_read, rvalid_o);
                if (note.is_read) check8("read data", note.data, rdata_o);
            end
        end
    end

    // ----------------------------------------
    // Driver
    // ----------------------------------------
    task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check1("ready", 1'b1, ready_o);
        req_i   = 1'b1;
        we_i    = w;
        addr_i  = a;
        wdata_i = d;
        notes.push_back('{!w, w ? d : expect_byte(a)});
        if (w) shadow[int'(a)] = d;
        @(posedge ref_clk_i);
        #1;
        req_i   = 1'b0;
        we_i    = 1'($urandom);
        addr_i  = 17'($urandom);
        wdata_i = 8'($urandom);
    endtask

    task automatic drain();
        // Stay off the edge so the next stimulus keeps its fixed skew
        for (int n = 0; n < 100 && notes.size() != 0; n++)
        begin
            @(posedge ref_clk_i);
            #1;
        end
        check1("results drained", 1'b1, notes.size() == 0);
    endtask

    task automatic reset_pins();
        check1("primary select", 1'b1, pins.primary_select_n);
        check1("secondary select", 1'b1, pins.secondary_select);
        check1("write strobe", 1'b1, pins.we_n);
        check1("output drive", 1'b1, pins.oe_n);
        check1("bus drive", 1'b0, pins.data_bus_oe);
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        logic [16:0] base;
        void'($urandom(32'h50C7));
        repeat (12) @(posedge ref_clk_i);
        #1;
        reset_pins();
        nrst_i = 1'b1;
        for (int r = 0; r < 4; r++)
        begin
            base = (r == 0) ? 17'h00000 : (r == 1) ? 17'h1FFF8 : {14'($urandom), 3'h0};
            for (int c = 0; c < 8; c++) op(1'b1, base + 17'(c), 8'($urandom));
            op(1'b0, base, 8'h00);
            for (int c = 1; c < 8; c++) op(1'b0, base + 17'(c), 8'h00);
            op(1'b1, base + 17'h00005, 8'($urandom));
            op(1'b0, base + 17'h00005, 8'h00);
            op(1'b0, base + 17'h00001, 8'h00);
            op(1'b0, base ^ 17'h00AA8, 8'h00);
        end
        drain();
        // Reset with the row left open must still close it cleanly
        nrst_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        reset_pins();
        nrst_i = 1'b1;
        op(1'b0, 17'h1FFFF, 8'h00);
        drain();
        foreach (shadow[a]) check8("array byte", shadow[a], nvp_mem_model_i.mem[a]);
        check1("pin timing", 1'b0, viol != 0);
        stop_test();
    end

    // Run needs about 8 us; fifteen times that cuts a hang
    initial
    begin
        #120us;
        check1("watchdog", 1'b0, 1'b1);
        stop_test();
    end
endmodule
